// ---- design/mpgb_gpio_bank.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// RL1 - every port B pin has a weak pull-up, one shared control
// RL2 - port B pins 7..4 take part in change detection, pins 3..0 do not
// RL3 - input pins 7..4 compared with value of last port B read, ORed, set flag (code also takes the snapshot on port B data writes)
// RL4 - clearing option bit 7 enables pull-ups; outputs and reset force them off
// RL5 - port B pin 0 is external interrupt input, hysteresis when used so
// RL6 - port C is 8 bits, each pin direction from its direction bit
// RL7 - enabled peripheral overrides port C direction to output or input
// RL8 - software avoids read-modify-write on port C direction during override
// RL9 - per-pin select picks port C output from latch or peripheral
// RL10 - peripheral output enable counts only while peripheral select active
// RL11 - port D is 8 bits, each pin direction from its direction bit
// RL12 - bit 4 of port E direction register makes port D parallel slave port
// RL13 - port E has three pins, direction from low three register bits
// RL14 - in parallel mode port E pins are read, write, select controls
// RL15 - software sets port E inputs and digital before parallel mode
// RL16 - port E pins configured analog read as zero
// RL17 - software keeps analog port E pins configured as inputs
// RL18 - after power-on reset port E pins are analog and read zero
// RL19 - direction bit set means high impedance input, clear drives latch
// RL20 - port read returns pins, write loads latch
module mpgb_gpio_bank
    import mpgb_pkg::*;
(
    input  wire logic       sys_clk,          // system clock, 40 MHz
    input  wire logic       reset_n,          // asynchronous reset, active low
    input  wire logic       clk_en,           // freezes all state but the reset synchroniser while low
    // register port
    input  wire logic [7:0] reg_addr,         // register address
    input  wire logic [7:0] reg_wdata,        // write data
    input  wire logic       reg_wr,           // write strobe
    input  wire logic       reg_rd,           // read strobe
    output logic      [7:0] reg_rdata,        // read data, cycle after strobe
    // port B pins
    input  wire logic [7:0] pin_b_i,          // pin levels
    output logic      [7:0] pin_b_o,          // output latch
    output logic      [7:0] pin_b_oe,         // driver enable
    output logic      [7:0] pullup_en,        // weak pull-up per pin
    output logic            ext_irq_pin,      // synchronised pin 0 level
    output logic            ext_irq_hyst_en,  // schmitt buffer on pin 0
    output logic            ext_irq_edge_select, // edge polarity to irq logic
    output logic      [5:0] timer_options,    // low option bits to timer
    output logic            pin_change_flag,  // change flag level
    // port C pins and peripherals
    input  wire logic [7:0] pin_c_i,          // pin levels
    output logic      [7:0] pin_c_o,          // pin drive value
    output logic      [7:0] pin_c_oe,         // driver enable
    input  wire logic [7:0] periph_sel,       // 1: peripheral owns output
    input  wire logic [7:0] periph_out,       // peripheral output data
    input  wire logic [7:0] periph_oe,        // peripheral output enable
    input  wire logic [7:0] periph_ovr_en,    // direction override active
    input  wire logic [7:0] periph_ovr_dir,   // forced direction, 1 input
    output logic      [7:0] pin_c_s,          // synchronised levels to peripherals
    // port D pins
    input  wire logic [7:0] pin_d_i,          // pin levels
    output logic      [7:0] pin_d_o,          // output latch
    output logic      [7:0] pin_d_oe,         // driver enable
    // port E pins and parallel port engine
    input  wire logic [2:0] pin_e_i,          // pin levels
    output logic      [2:0] pin_e_o,          // output latch
    output logic      [2:0] pin_e_oe,         // driver enable
    output logic            parallel_port_mode, // parallel slave mode
    output logic            par_read_strobe_n,  // read control, active low
    output logic            par_write_strobe_n, // write control, active low
    output logic            par_select_n,       // chip select, active low
    input  wire logic       input_buffer_full,     // status from engine
    input  wire logic       output_buffer_full,    // status from engine
    input  wire logic       input_buffer_overflow, // status from engine
    output logic      [2:0] analog_pin_config_field // to converter mux
);
    logic       rst_meta_q;
    logic       rst_q;
    logic [7:0] b_s;
    logic [7:0] d_s;
    logic [2:0] e_s;

    logic [7:0] b_latch_q;
    logic [7:0] c_latch_q;
    logic [7:0] d_latch_q;
    logic [2:0] e_latch_q;
    logic [7:0] b_dir_q;
    logic [7:0] c_dir_q;
    logic [7:0] d_dir_q;
    logic [4:0] e_dir_q;
    logic [7:0] options_q;
    logic [2:0] analog_q;
    logic       ext_irq_en_q;
    logic       change_flag_q;
    logic       change_flag_d;
    logic [3:0] b_last_q;
    logic [7:0] rdata_q;

    // reset release through two flops; assert stays asynchronous
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    // every pin group is synchronised before any logic looks at it
    mpgb_pin_sync #(.WIDTH(8)) u_sync_b (
        .sys_clk (sys_clk),
        .rst_n   (rst_q),
        .clk_en  (clk_en),
        .pin_i   (pin_b_i),
        .pin_s   (b_s)
    );
    mpgb_pin_sync #(.WIDTH(8)) u_sync_c (
        .sys_clk (sys_clk),
        .rst_n   (rst_q),
        .clk_en  (clk_en),
        .pin_i   (pin_c_i),
        .pin_s   (pin_c_s)
    );
    mpgb_pin_sync #(.WIDTH(8)) u_sync_d (
        .sys_clk (sys_clk),
        .rst_n   (rst_q),
        .clk_en  (clk_en),
        .pin_i   (pin_d_i),
        .pin_s   (d_s)
    );
    mpgb_pin_sync #(.WIDTH(3)) u_sync_e (
        .sys_clk (sys_clk),
        .rst_n   (rst_q),
        .clk_en  (clk_en),
        .pin_i   (pin_e_i),
        .pin_s   (e_s)
    );

    // address decode
    wire        acc_en  = clk_en;
    wire        wr_b    = acc_en & reg_wr & (reg_addr == OFS_B_DATA);
    wire        wr_c    = acc_en & reg_wr & (reg_addr == OFS_C_DATA);
    wire        wr_d    = acc_en & reg_wr & (reg_addr == OFS_D_DATA);
    wire        wr_e    = acc_en & reg_wr & (reg_addr == OFS_E_DATA);
    wire        wr_irq  = acc_en & reg_wr & (reg_addr == OFS_IRQ_CTRL);
    wire        wr_opt  = acc_en & reg_wr & (reg_addr == OFS_OPTIONS);
    wire        wr_bdir = acc_en & reg_wr & (reg_addr == OFS_B_DIR);
    wire        wr_cdir = acc_en & reg_wr & (reg_addr == OFS_C_DIR);
    wire        wr_ddir = acc_en & reg_wr & (reg_addr == OFS_D_DIR);
    wire        wr_edir = acc_en & reg_wr & (reg_addr == OFS_E_DIR);
    wire        wr_anl  = acc_en & reg_wr & (reg_addr == OFS_ANALOG_CFG);
    wire        rd_b    = acc_en & reg_rd & (reg_addr == OFS_B_DATA);

    // port E analog decode: only codes 11x make the pins digital
    wire        e_digital   = (analog_q[2:1] == 2'h3);
    wire [2:0]  e_read      = e_digital ? e_s : 3'h0;               // RL16 RL18
    wire        par_mode    = e_dir_q[POS_PAR_MODE];

    // port C effective direction: peripheral override beats the register
    wire [7:0]  c_dir_eff   = (periph_ovr_en & periph_ovr_dir)
                            | (~periph_ovr_en & c_dir_q);           // RL7 RL6

    // change detection on input pins 7..4 against snapshot of last port B read or write
    wire [3:0]  b_in_hi     = b_dir_q[7:CHANGE_LO];                 // RL2
    wire [3:0]  b_mismatch  = (b_s[7:CHANGE_LO] ^ b_last_q) & b_in_hi; // RL3
    wire        change_hit  = |b_mismatch;                          // RL3

    // read mux for the register port
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            OFS_B_DATA:     rd_mux = b_s;                           // RL20
            OFS_C_DATA:     rd_mux = pin_c_s;                       // RL20
            OFS_D_DATA:     rd_mux = d_s;                           // RL20
            OFS_E_DATA:     rd_mux = {5'h00, e_read};               // RL16
            OFS_IRQ_CTRL:   rd_mux = {3'h0, ext_irq_en_q, 3'h0, change_flag_q};
            OFS_OPTIONS:    rd_mux = options_q;
            OFS_B_DIR:      rd_mux = b_dir_q;
            OFS_C_DIR:      rd_mux = c_dir_q;
            OFS_D_DIR:      rd_mux = d_dir_q;
            OFS_E_DIR:      rd_mux = {input_buffer_full, output_buffer_full,
                                      input_buffer_overflow, e_dir_q[4], 1'b0,
                                      e_dir_q[2:0]};
            OFS_ANALOG_CFG: rd_mux = {5'h00, analog_q};
            default:        rd_mux = 8'h00;   // unmapped reads as zero
        endcase
    end

    // output latches: a write loads the latch, pins are not touched
    always_ff @(posedge sys_clk or negedge rst_q) begin
        if (!rst_q) begin
            b_latch_q <= RST_LATCH;
            c_latch_q <= RST_LATCH;
            d_latch_q <= RST_LATCH;
            e_latch_q <= RST_LATCH[2:0];
        end else begin
            if (wr_b) b_latch_q <= reg_wdata;                       // RL20
            if (wr_c) c_latch_q <= reg_wdata;                       // RL20
            if (wr_d) d_latch_q <= reg_wdata;                       // RL20
            if (wr_e) e_latch_q <= reg_wdata[2:0];                  // RL20
        end
    end

    // direction registers; all pins come up as inputs
    always_ff @(posedge sys_clk or negedge rst_q) begin
        if (!rst_q) begin
            b_dir_q <= RST_DIR;
            c_dir_q <= RST_DIR;
            d_dir_q <= RST_DIR;
            e_dir_q <= RST_E_DIR;
        end else begin
            if (wr_bdir) b_dir_q <= reg_wdata;
            if (wr_cdir) c_dir_q <= reg_wdata;                      // RL6
            if (wr_ddir) d_dir_q <= reg_wdata;                      // RL11
            if (wr_edir) e_dir_q <= reg_wdata[4:0];                 // RL13 RL12
        end
    end

    // option and analog configuration; analog_q reset makes port E analog
    always_ff @(posedge sys_clk or negedge rst_q) begin
        if (!rst_q) begin
            options_q    <= RST_OPTIONS;                            // RL4
            analog_q     <= RST_ANALOG_CFG;                         // RL18
            ext_irq_en_q <= 1'b0;
        end else begin
            if (wr_opt) options_q <= reg_wdata;
            if (wr_anl) analog_q  <= reg_wdata[2:0];
            if (wr_irq) ext_irq_en_q <= reg_wdata[POS_EXT_IRQ_EN];
        end
    end

    // flag: a mismatch in the clearing cycle wins over the clear
    always_comb begin
        change_flag_d = change_flag_q;
        if (wr_irq && !reg_wdata[POS_CHANGE_FLAG]) begin
            change_flag_d = 1'b0;
        end
        if (change_hit) begin
            change_flag_d = 1'b1;                                   // RL3
        end
    end

    // snapshot refreshed on a port B data read or write, ending the mismatch
    always_ff @(posedge sys_clk or negedge rst_q) begin
        if (!rst_q) begin
            change_flag_q <= 1'b0;
            b_last_q      <= 4'h0;
        end else if (clk_en) begin
            change_flag_q <= change_flag_d;
            if (rd_b || wr_b) begin
                b_last_q <= b_s[7:CHANGE_LO];                       // RL3
            end
        end
    end

    // read data held from the strobe edge until the next edge with clk_en high
    always_ff @(posedge sys_clk or negedge rst_q) begin
        if (!rst_q) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // port B drivers and pull-ups; pull-up dropped on output pins
    assign pin_b_o             = b_latch_q;
    assign pin_b_oe            = ~b_dir_q;                          // RL19
    assign pullup_en           = {8{~options_q[POS_PULLUP_EN_N]}} & b_dir_q; // RL1 RL4
    assign ext_irq_pin         = b_s[0];                            // RL5
    assign ext_irq_hyst_en     = ext_irq_en_q;                      // RL5
    assign ext_irq_edge_select = options_q[POS_EDGE_SEL];
    assign timer_options       = options_q[5:0];
    assign pin_change_flag     = change_flag_q;

    // port C: peripheral select steers data, its enable only counts when selected
    assign pin_c_o  = (periph_sel & periph_out) | (~periph_sel & c_latch_q); // RL9
    assign pin_c_oe = ~c_dir_eff & (~periph_sel | periph_oe);       // RL10 RL19

    // port D: in parallel mode the direction register is ignored and the
    // bus only drives while the external master reads with select low
    wire   par_read = par_mode & ~e_s[0] & ~e_s[2];                 // RL12
    assign pin_d_o  = d_latch_q;
    assign pin_d_oe = par_mode ? {8{par_read}} : ~d_dir_q;          // RL11 RL12 RL19

    // port E: control inputs in parallel mode, never driven then
    assign pin_e_o            = e_latch_q;
    assign pin_e_oe           = par_mode ? 3'h0 : ~e_dir_q[2:0];    // RL14 RL19
    assign parallel_port_mode = par_mode;
    assign par_read_strobe_n  = par_mode ? e_s[0] : 1'b1;           // RL14
    assign par_write_strobe_n = par_mode ? e_s[1] : 1'b1;           // RL14
    assign par_select_n       = par_mode ? e_s[2] : 1'b1;           // RL14
    assign analog_pin_config_field = analog_q;
endmodule : mpgb_gpio_bank

// ---- design/mpgb_pkg.sv ----
package mpgb_pkg;
    // register offsets on the core data bus
    localparam logic [7:0] OFS_B_DATA     = 8'h06;
    localparam logic [7:0] OFS_C_DATA     = 8'h07;
    localparam logic [7:0] OFS_D_DATA     = 8'h08;
    localparam logic [7:0] OFS_E_DATA     = 8'h09;
    localparam logic [7:0] OFS_IRQ_CTRL   = 8'h0b;
    localparam logic [7:0] OFS_OPTIONS    = 8'h81;
    localparam logic [7:0] OFS_B_DIR      = 8'h86;
    localparam logic [7:0] OFS_C_DIR      = 8'h87;
    localparam logic [7:0] OFS_D_DIR      = 8'h88;
    localparam logic [7:0] OFS_E_DIR      = 8'h89;
    localparam logic [7:0] OFS_ANALOG_CFG = 8'h9f;

    // field positions
    localparam int POS_PULLUP_EN_N   = 7;
    localparam int POS_EDGE_SEL      = 6;
    localparam int POS_PAR_MODE      = 4;
    localparam int POS_IN_FULL       = 7;
    localparam int POS_OUT_FULL      = 6;
    localparam int POS_IN_OVERFLOW   = 5;
    localparam int POS_EXT_IRQ_EN    = 4;
    localparam int POS_CHANGE_FLAG   = 0;
    localparam int CHANGE_LO         = 4;

    // values after reset
    localparam logic [7:0] RST_OPTIONS    = 8'hff;
    localparam logic [7:0] RST_DIR        = 8'hff;
    localparam logic [4:0] RST_E_DIR      = 5'h07;
    localparam logic [2:0] RST_ANALOG_CFG = 3'h0;
    localparam logic [7:0] RST_LATCH      = 8'h00;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
endpackage : mpgb_pkg

// ---- design/mpgb_pin_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for a group of pins; only stage two is visible outside
module mpgb_pin_sync
    import mpgb_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,   // system clock
    input  wire logic             rst_n,     // synchronised reset, active low
    input  wire logic             clk_en,    // freezes state while low
    input  wire logic [WIDTH-1:0] pin_i,     // raw pin levels
    output logic      [WIDTH-1:0] pin_s      // synchronised levels
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            pin_s  <= '0;
        end else if (clk_en) begin
            meta_q <= pin_i;
            pin_s  <= meta_q;
        end
    end
endmodule : mpgb_pin_sync

// ---- verification/mpgb_assertions.sv ----
`timescale 1ns/1ps
// port-level checks of the gpio bank, bound onto the top module
module mpgb_checker
    import mpgb_pkg::*;
(
    input wire logic       sys_clk,            // clock
    input wire logic       reset_n,            // async reset
    input wire logic       clk_en,             // run enable
    input wire logic [7:0] reg_addr,           // address
    input wire logic [7:0] reg_wdata,          // write data
    input wire logic       reg_wr,             // write strobe
    input wire logic       reg_rd,             // read strobe
    input wire logic [7:0] reg_rdata,          // read data
    input wire logic [7:0] pin_b_oe,           // b drive
    input wire logic [7:0] pullup_en,          // b pull-ups
    input wire logic       ext_irq_hyst_en,    // schmitt on
    input wire logic [7:0] pin_c_o,            // c value
    input wire logic [7:0] pin_c_oe,           // c drive
    input wire logic [7:0] periph_sel,         // c owner
    input wire logic [7:0] periph_out,         // c periph data
    input wire logic [7:0] periph_oe,          // c periph drive
    input wire logic [7:0] periph_ovr_en,      // c override
    input wire logic [7:0] periph_ovr_dir,     // c forced dir
    input wire logic [2:0] pin_e_i,            // e pins
    input wire logic       parallel_port_mode, // slave mode
    input wire logic       par_read_strobe_n,  // read control
    input wire logic       par_write_strobe_n, // write control
    input wire logic       par_select_n        // select control
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // a register write taken at this edge
    sequence s_wr(a);
        reg_wr && clk_en && reg_addr == a;
    endsequence
    // slave mode held long enough for the synchroniser to fill
    sequence s_par_held;
        parallel_port_mode [*3];
    endsequence
    logic [2:0] strobes;
    // control strobes gathered in pin order
    assign strobes = {par_select_n, par_write_strobe_n, par_read_strobe_n};
    a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside an answer");
    a_b_dir_drive: assert property (s_wr(OFS_B_DIR) |=> pin_b_oe == ~$past(reg_wdata))
        else $error("port b drivers do not follow direction write");
    a_pullup_out: assert property ((pullup_en & pin_b_oe) == 8'h00)
        else $error("pull-up on while pin drives");
    a_c_override: assert property (((periph_ovr_en & periph_ovr_dir & pin_c_oe) == 8'h00)
        && ((periph_ovr_en & ~periph_ovr_dir & ~periph_sel & ~pin_c_oe) == 8'h00))
        else $error("port c direction override ignored");
    a_c_periph_oe: assert property ((periph_sel & ~periph_oe & pin_c_oe) == 8'h00)
        else $error("port c drives without peripheral enable");
    a_c_select: assert property ((pin_c_o & periph_sel) == (periph_out & periph_sel))
        else $error("port c selected pins not from peripheral");
    a_par_idle: assert property (!parallel_port_mode |-> strobes == 3'h7)
        else $error("slave controls active outside slave mode");
    a_par_follow: assert property (s_par_held |-> strobes == $past(pin_e_i, 2))
        else $error("slave controls do not follow port e pins");
    a_mode_write: assert property (s_wr(OFS_E_DIR)
        |=> parallel_port_mode == $past(reg_wdata[POS_PAR_MODE]))
        else $error("slave mode bit not taken");
    a_hyst_write: assert property (s_wr(OFS_IRQ_CTRL)
        |=> ext_irq_hyst_en == $past(reg_wdata[POS_EXT_IRQ_EN]))
        else $error("hysteresis does not follow irq enable");
endmodule : mpgb_checker

// ---- verification/mpgb_pin_model.sv ----
`timescale 1ns/1ps
// outside circuitry on the pins; port b may float onto its pull-ups
module mpgb_pin_model (
    input  wire logic       sys_clk,  // clock for float pattern
    input  wire logic [7:0] pin_b_o,  // b latch
    input  wire logic [7:0] pin_b_oe, // b drive
    input  wire logic [7:0] pullup_en, // b pull-ups
    input  wire logic       float_b,  // 1: nothing drives b
    input  wire logic [7:0] ext,      // outside level b c d
    input  wire logic [7:0] pin_c_o,  // c value
    input  wire logic [7:0] pin_c_oe, // c drive
    input  wire logic [7:0] pin_d_o,  // d latch
    input  wire logic [7:0] pin_d_oe, // d drive
    input  wire logic [2:0] ext_e,    // outside level e
    input  wire logic [2:0] pin_e_o,  // e latch
    input  wire logic [2:0] pin_e_oe, // e drive
    output logic      [7:0] pin_b_i,  // b wire
    output logic      [7:0] pin_c_i,  // c wire
    output logic      [7:0] pin_d_i,  // d wire
    output logic      [2:0] pin_e_i   // e wire
);
    logic [7:0] b_last_q;
    // an undriven pin with no pull-up shows the inverse of its last level
    assign pin_b_i = (pin_b_oe & pin_b_o)
        | (~pin_b_oe & (float_b ? (pullup_en | ~b_last_q) : ext));
    assign pin_c_i = (pin_c_oe & pin_c_o) | (~pin_c_oe & ext);
    assign pin_d_i = (pin_d_oe & pin_d_o) | (~pin_d_oe & ext);
    assign pin_e_i = (pin_e_oe & pin_e_o) | (~pin_e_oe & ext_e);
    // last wire level for the float pattern
    always_ff @(posedge sys_clk) begin
        b_last_q <= pin_b_i;
    end
endmodule : mpgb_pin_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import mpgb_pkg::*;
    logic       sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, float_b = 1'b0;
    logic       input_buffer_full = 1'b0, output_buffer_full = 1'b0, pend = 1'b0;
    logic       input_buffer_overflow = 1'b0, clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ext = 8'h00, periph_sel = 8'h00;
    logic [7:0] periph_out = 8'h00, periph_oe = 8'h00, periph_ovr_en = 8'h00, periph_ovr_dir = 8'h00;
    logic [7:0] reg_rdata, pin_b_i, pin_b_o, pin_b_oe, pullup_en, pin_c_i, pin_c_o, pin_c_oe;
    logic [7:0] pin_c_s, pin_d_i, pin_d_o, pin_d_oe, w, v, exp_v;
    logic [2:0] pin_e_i, pin_e_o, pin_e_oe, analog_pin_config_field, ext_e = 3'h0;
    logic [5:0] timer_options;
    logic       ext_irq_pin, ext_irq_hyst_en, ext_irq_edge_select, pin_change_flag;
    logic       parallel_port_mode, par_read_strobe_n, par_write_strobe_n, par_select_n;
    logic [7:0] exp_q[$];
    int         num_errors = 0, samples_checked = 0, seed = 20, i;
    mpgb_gpio_bank DUT (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pin_b_i, .pin_b_o, .pin_b_oe, .pullup_en, .ext_irq_pin,
        .ext_irq_hyst_en, .ext_irq_edge_select, .timer_options, .pin_change_flag, .pin_c_i,
        .pin_c_o, .pin_c_oe, .periph_sel, .periph_out, .periph_oe, .periph_ovr_en,
        .periph_ovr_dir, .pin_c_s, .pin_d_i, .pin_d_o, .pin_d_oe, .pin_e_i, .pin_e_o,
        .pin_e_oe, .parallel_port_mode, .par_read_strobe_n, .par_write_strobe_n,
        .par_select_n, .input_buffer_full, .output_buffer_full, .input_buffer_overflow,
        .analog_pin_config_field);
    mpgb_pin_model u_pins (.sys_clk, .pin_b_o, .pin_b_oe, .pullup_en, .float_b, .ext,
        .pin_c_o, .pin_c_oe, .pin_d_o, .pin_d_oe, .ext_e, .pin_e_o, .pin_e_oe, .pin_b_i,
        .pin_c_i, .pin_d_i, .pin_e_i);
    // 40 mhz clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] g);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task final_report;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // read data stand one edge after the strobe is taken
    always @(posedge sys_clk) begin
        if (pend) begin
            exp_v = exp_q.pop_front();
            cmp("reg_rdata", exp_v, reg_rdata);
        end
        pend <= reg_rd;
    end
    // hang guard, far beyond the some 190 cycles the run needs
    initial begin
        #125000;
        num_errors++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        wt(3);
        rd(OFS_OPTIONS, RST_OPTIONS);
        rd(OFS_B_DIR, RST_DIR);
        rd(OFS_C_DIR, RST_DIR);
        rd(OFS_D_DIR, RST_DIR);
        rd(OFS_E_DIR, 8'h07);
        rd(OFS_ANALOG_CFG, 8'h00);
        rd(8'h55, 8'h00);
        ext_e <= 3'h5;
        wt(3);
        rd(OFS_E_DATA, 8'h00);
        cmp("pullup_en", 8'h00, pullup_en);
        cmp("pin_e_oe", 8'h00, pin_e_oe);
        // random directions read back and steer the drivers
        for (i = 0; i < 6; i++) begin
            w = 8'($random(seed));
            wr(OFS_B_DIR + 8'(i % 3), w);
            rd(OFS_B_DIR + 8'(i % 3), w);
            wt(1);
            cmp("pin_oe", ~w, i % 3 == 0 ? pin_b_oe : i % 3 == 1 ? pin_c_oe : pin_d_oe);
        end
        // latch driven out, then the pins sensed as inputs
        for (i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            ext <= 8'($random(seed));
            wr(OFS_B_DATA + 8'(i), v);
            wr(OFS_B_DIR + 8'(i), 8'h00);
            wt(3);
            rd(OFS_B_DATA + 8'(i), v);
            wr(OFS_B_DIR + 8'(i), 8'hff);
            wt(3);
            rd(OFS_B_DATA + 8'(i), ext);
        end
        // pull-ups reach input pins only; low half drives the latch
        wr(OFS_OPTIONS, 8'h7f);
        wr(OFS_B_DATA, 8'h5a);
        wr(OFS_B_DIR, 8'hf0);
        float_b <= 1'b1;
        wt(3);
        cmp("pullup_en", 8'hf0, pullup_en);
        cmp("edge_select", 8'h01, ext_irq_edge_select);
        cmp("timer_options", 8'h3f, timer_options);
        rd(OFS_B_DATA, 8'hfa);
        // change detection on inputs 7..4, snapshot refreshed by reads
        float_b <= 1'b0;
        ext <= 8'h00;
        wr(OFS_B_DIR, 8'hff);
        wt(3);
        rd(OFS_B_DATA, 8'h00);
        wr(OFS_IRQ_CTRL, 8'h00);
        rd(OFS_IRQ_CTRL, 8'h00);
        ext <= 8'h0f;
        wt(4);
        rd(OFS_IRQ_CTRL, 8'h00);
        ext <= 8'h4f;
        wt(4);
        cmp("pin_change_flag", 8'h01, pin_change_flag);
        wr(OFS_IRQ_CTRL, 8'h00);
        rd(OFS_IRQ_CTRL, 8'h01);
        rd(OFS_B_DATA, 8'h4f);
        wr(OFS_IRQ_CTRL, 8'h10);
        rd(OFS_IRQ_CTRL, 8'h10);
        wt(1);
        cmp("ext_irq_hyst_en", 8'h01, ext_irq_hyst_en);
        cmp("ext_irq_pin", 8'h01, ext_irq_pin);
        // port c override and peripheral select; no read-modify-write of its direction
        periph_ovr_en <= 8'hff;
        periph_ovr_dir <= 8'h0f;
        wt(1);
        cmp("pin_c_oe", 8'hf0, pin_c_oe);
        periph_sel <= 8'hff;
        periph_oe <= 8'h33;
        periph_out <= 8'ha5;
        wt(1);
        cmp("pin_c_oe", 8'h30, pin_c_oe);
        cmp("pin_c_o", 8'ha5, pin_c_o);
        // random peripheral traffic, judged by the checker
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            {periph_sel, periph_out, periph_oe, periph_ovr_en} <= $random(seed);
            periph_ovr_dir <= 8'($random(seed));
        end
        // port e made digital inputs, then slave mode controls
        wr(OFS_ANALOG_CFG, 8'h06);
        wt(3);
        cmp("analog_field", 8'h06, analog_pin_config_field);
        rd(OFS_E_DATA, 8'h05);
        {input_buffer_full, output_buffer_full, input_buffer_overflow} <= 3'($random(seed));
        ext_e <= 3'h2;
        wr(OFS_E_DIR, 8'h17);
        wt(3);
        cmp("strobes", 8'h02, {par_select_n, par_write_strobe_n, par_read_strobe_n});
        rd(OFS_E_DIR, {input_buffer_full, output_buffer_full, input_buffer_overflow,
            5'h17});
        clk_en <= 1'b0;
        wr(OFS_D_DIR, 8'h00);
        clk_en <= 1'b1;
        rd(OFS_D_DIR, RST_DIR);
        wt(3);
        final_report();
    end
endmodule : testbench
bind mpgb_gpio_bank mpgb_checker u_chk (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pin_b_oe, .pullup_en, .ext_irq_hyst_en, .pin_c_o,
    .pin_c_oe, .periph_sel, .periph_out, .periph_oe, .periph_ovr_en, .periph_ovr_dir,
    .pin_e_i, .parallel_port_mode, .par_read_strobe_n, .par_write_strobe_n, .par_select_n);
